// ### rtl/gcd_detector.sv
// gap command detector: quick read patterns, calibration and 1-of-16 symbols
//
// Summary of operation
// - a quick read command is five gaps among nine positions, 1.575 ms total
// - request yields max slot count, max transmit count and downlink speed
// - skip pattern yields downlink speed only, no slot or transmit values
// - slot count 1 patterns for transmit counts 1, 2, 4, normal and fast
// - slot count 16 patterns for transmit counts 1, 2, 4, normal and fast
// - slot count 64, transmit 1: (1,2,4,5,7) normal, (1,3,4,5,7) fast
// - skip pattern (1,2,3,5,7) normal, (1,3,5,7,9) fast
// - symbol lasts 2.8 ms normal, 160 us fast, carrying one nibble
// - decoded speed sets the expected calibration slot; uplink rate stays 70 kHz
// - single-tag mode replies every slot until match or transmit count ends
// - calibration pulses precede symbol data and set the decoder time base
// - calibration is three gaps at positions 0, 6 and 14 of 16
// - each symbol holds exactly one gap; its position is the nibble
// - command and address nibbles arrive high first, data low first
module gcd_detector
  import gcd_pkg::*;
#(
  parameter int QR_SLOT   = QR_SLOT_CYC,
  parameter int NORM_SLOT = NORM_SLOT_CYC,
  parameter int FAST_SLOT = FAST_SLOT_CYC,
  parameter int REPLY_SLT = REPLY_SLOT_CYC,
  parameter int CW        = 20
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // demodulated carrier, high while the carrier is absent
  input  wire logic        GAP,
  // quick read results
  output logic             QR_REQ,
  output logic             QR_SKIP,
  output logic             SPEED_FAST,
  output logic      [6:0]  MAX_SLOTS,
  output logic      [2:0]  MAX_TX,
  // symbol stream
  output logic             CAL_DONE,
  output logic      [3:0]  NIBBLE,
  output logic             NIBBLE_VALID,
  output logic      [5:0]  NIBBLE_IDX,
  output logic             XFER_END,
  // single-tag replies
  input  wire logic        MATCH_OK,
  output logic             REPLY_REQ,
  output logic             REPLY_ACTIVE
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  // calibration is told from a quick read by where its second gap rounds to
  if (QR_SLOT < 4 || NORM_SLOT < 4 || FAST_SLOT < 4 || REPLY_SLT < 2 ||
      FAST_SLOT * 12 >= QR_SLOT || NORM_SLOT * 12 < QR_SLOT * 5 ||
      QR_SLOT * 16 >= 2 ** CW || NORM_SLOT * 16 >= 2 ** CW ||
      REPLY_SLT >= 2 ** CW) begin : g_chk
    $error("gcd_detector: slot counts out of range");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  gcd_state_type   st_r;
  gcd_state_type   st_nxt;
  logic            gap_d_r;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  logic [CW-1:0]   slot_r;
  logic [CW-1:0]   slot_nxt;
  logic [CW-1:0]   meas_r;
  logic [CW-1:0]   meas_nxt;
  logic [2:0]      div6_r;
  logic [2:0]      div6_nxt;
  logic [4:0]      idx_r;
  logic [4:0]      idx_nxt;
  logic [8:0]      mask_r;
  logic [8:0]      mask_nxt;
  logic            seen_r;
  logic            seen_nxt;
  logic [3:0]      val_r;
  logic [3:0]      val_nxt;
  logic [1:0]      ctrl_r;
  logic            speed_r;
  logic [1:0]      slots_r;
  logic [1:0]      tx_r;
  logic [5:0]      nib_cnt_r;
  logic [3:0]      nib_r;
  logic            qr_req_r;
  logic            qr_skip_r;
  logic            cal_done_r;
  logic            nib_vld_r;
  logic            xfer_end_r;
  logic [31:0]     rdata_r;
  logic            rep_act_r;
  logic [2:0]      rep_left_r;
  logic [CW-1:0]   rep_tmr_r;
  logic            rep_req_r;

  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  wire logic          gap_rise  = GAP & ~gap_d_r;
  wire logic          slot_done = (cnt_r == slot_r - {{(CW-1){1'b0}}, 1'b1});
  wire logic          enabled   = ctrl_r[CTRL_EN_BIT];
  wire gcd_qr_type    qr        = qr_decode(mask_r);
  // evaluated at the centre of the ninth position, half a slot after it starts
  wire logic          qr_eval   = (st_r == ST_QREAD) && (idx_r == 5'(QR_POSITIONS));
  wire logic          qr_hit    = qr_eval && qr.hit;
  wire logic [CW-1:0] qr_w      = CW'(QR_SLOT);
  wire logic [CW-1:0] exp_slot  = speed_r ? CW'(FAST_SLOT) : CW'(NORM_SLOT);
  // a measured slot far from the expected one is not a calibration
  wire logic          cal_ok    = (meas_r >= (exp_slot >> 1)) &&
                                  (meas_r <= (exp_slot << 1));
  wire logic          qr_second = (idx_r == 5'h01) || (idx_r == 5'h02);
  wire logic          sym_end   = slot_done && (idx_r == 5'h0F);
  wire logic          wr_ctrl   = REG_WR && (REG_ADDR == ADDR_CTRL);
  wire logic          single    = qr_hit && !qr.skip && (qr.slots == 2'h0);
  wire logic [2:0]    tx_val    = 3'h1 << qr.tx;

  // ----------------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = slot_done ? '0 : cnt_r + {{(CW-1){1'b0}}, 1'b1};
    idx_nxt  = slot_done ? idx_r + 5'h01 : idx_r;
    slot_nxt = slot_r;
    meas_nxt = meas_r;
    div6_nxt = div6_r;
    mask_nxt = mask_r;
    seen_nxt = seen_r;
    val_nxt  = val_r;
    case (st_r)
      ST_IDLE: begin
        cnt_nxt  = cnt_r;
        idx_nxt  = idx_r;
        if (gap_rise && enabled) begin
          // rounding: the index steps at each slot centre, half a slot after the slot starts
          st_nxt   = ST_FIRST;
          slot_nxt = qr_w;
          cnt_nxt  = qr_w >> 1;
          idx_nxt  = 5'h00;
          meas_nxt = '0;
          div6_nxt = 3'h1;
          mask_nxt = 9'h001;
          seen_nxt = 1'b1;
        end
      end
      ST_FIRST: begin
        div6_nxt = (div6_r == 3'h5) ? 3'h0 : div6_r + 3'h1;
        meas_nxt = (div6_r == 3'h5) ? meas_r + {{(CW-1){1'b0}}, 1'b1} : meas_r;
        if (gap_rise) begin
          if (qr_second) begin
            st_nxt   = ST_QREAD;
            mask_nxt = mask_r | (9'h001 << idx_r);
          end else if (cal_ok) begin
            // measured time to position 6, divided by six, is the slot
            st_nxt   = ST_CAL;
            slot_nxt = meas_r;
            cnt_nxt  = meas_r >> 1;
            idx_nxt  = 5'(CAL_POS_B);
            seen_nxt = 1'b0;
          end else begin
            st_nxt   = ST_IDLE;
          end
        end else if (idx_r == 5'(QR_POSITIONS)) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_QREAD: begin
        if (gap_rise && idx_r < 5'(QR_POSITIONS)) begin
          mask_nxt = mask_r | (9'h001 << idx_r);
        end
        if (qr_eval) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_CAL: begin
        if (gap_rise && !sym_end) begin
          if (idx_r == 5'(CAL_POS_C) && !seen_r) begin
            seen_nxt = 1'b1;
          end else begin
            st_nxt = ST_IDLE;
          end
        end else if (sym_end) begin
          idx_nxt  = 5'h00;
          seen_nxt = 1'b0;
          st_nxt   = seen_r ? ST_SYM : ST_IDLE;
        end
      end
      ST_SYM: begin
        if (gap_rise && !sym_end) begin
          if (!seen_r) begin
            seen_nxt = 1'b1;
            val_nxt  = idx_r[3:0];
          end else begin
            st_nxt = ST_IDLE;
          end
        end else if (sym_end) begin
          idx_nxt  = 5'h00;
          seen_nxt = 1'b0;
          st_nxt   = seen_r ? ST_SYM : ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (!enabled) begin
      st_nxt = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // frame registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      st_r    <= ST_IDLE;
      gap_d_r <= 1'b0;
      cnt_r   <= '0;
      slot_r  <= '0;
      meas_r  <= '0;
      div6_r  <= 3'h0;
      idx_r   <= 5'h00;
      mask_r  <= 9'h000;
      seen_r  <= 1'b0;
      val_r   <= 4'h0;
    end else begin
      st_r    <= st_nxt;
      gap_d_r <= GAP;
      cnt_r   <= cnt_nxt;
      slot_r  <= slot_nxt;
      meas_r  <= meas_nxt;
      div6_r  <= div6_nxt;
      idx_r   <= idx_nxt;
      mask_r  <= mask_nxt;
      seen_r  <= seen_nxt;
      val_r   <= val_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // results and symbol output
  // ----------------------------------------------------------------------
  wire logic sym_out   = (st_r == ST_SYM) && sym_end && seen_r;
  wire logic xfer_stop = ((st_r == ST_SYM) || (st_r == ST_CAL)) && (st_nxt == ST_IDLE);

  // nibbles leave in arrival order; the command layer reassembles them
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      speed_r    <= 1'b0;
      slots_r    <= 2'h0;
      tx_r       <= 2'h0;
      qr_req_r   <= 1'b0;
      qr_skip_r  <= 1'b0;
      cal_done_r <= 1'b0;
      nib_vld_r  <= 1'b0;
      nib_r      <= 4'h0;
      nib_cnt_r  <= 6'h00;
      xfer_end_r <= 1'b0;
    end else begin
      qr_req_r   <= qr_hit && !qr.skip;
      qr_skip_r  <= qr_hit && qr.skip;
      cal_done_r <= (st_r == ST_CAL) && (st_nxt == ST_SYM);
      nib_vld_r  <= sym_out;
      xfer_end_r <= xfer_stop;
      // hardware speed update wins over a software write
      if (qr_hit) begin
        speed_r <= qr.fast;
      end else if (wr_ctrl) begin
        speed_r <= REG_WDATA[CTRL_FAST_BIT];
      end
      if (qr_hit && !qr.skip) begin
        slots_r <= qr.slots;
        tx_r    <= qr.tx;
      end
      if (sym_out) begin
        nib_r     <= val_r;
        nib_cnt_r <= nib_cnt_r + 6'h01;
      end else if (st_r == ST_CAL) begin
        nib_cnt_r <= 6'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // single-tag reply pacing
  // ----------------------------------------------------------------------
  wire logic rep_fire = rep_act_r && (rep_tmr_r == '0);

  // a new request wins over a match in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      rep_act_r  <= 1'b0;
      rep_left_r <= 3'h0;
      rep_tmr_r  <= '0;
      rep_req_r  <= 1'b0;
    end else begin
      rep_req_r <= rep_fire && !MATCH_OK;
      if (single) begin
        rep_act_r  <= 1'b1;
        rep_left_r <= tx_val;
        rep_tmr_r  <= '0;
      end else if (MATCH_OK) begin
        rep_act_r <= 1'b0;
      end else if (rep_fire) begin
        rep_left_r <= rep_left_r - 3'h1;
        rep_tmr_r  <= CW'(REPLY_SLT - 1);
        rep_act_r  <= (rep_left_r != 3'h1);
      end else if (rep_act_r) begin
        rep_tmr_r <= rep_tmr_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  wire logic [31:0] status_w = {22'h000000, st_r, rep_act_r,
                                 tx_r, slots_r, speed_r, enabled};
  wire logic [31:0] rd_mux   = (REG_ADDR == ADDR_CTRL)   ? {30'h0, speed_r, ctrl_r[0]} :
                               (REG_ADDR == ADDR_STATUS) ? status_w :
                               (REG_ADDR == ADDR_SLOT)   ? 32'(slot_r) :
                               (REG_ADDR == ADDR_NIBBLE) ? {26'h0, nib_cnt_r[1:0], nib_r} :
                               32'h00000000;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      ctrl_r  <= CTRL_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= REG_WDATA[1:0];
      end
      rdata_r <= REG_RD ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA    = rdata_r;
  assign QR_REQ       = qr_req_r;
  assign QR_SKIP      = qr_skip_r;
  assign SPEED_FAST   = speed_r;
  assign MAX_SLOTS    = (slots_r == 2'h0) ? 7'h01 : (slots_r == 2'h1) ? 7'h10 : 7'h40;
  assign MAX_TX       = 3'h1 << tx_r;
  assign CAL_DONE     = cal_done_r;
  assign NIBBLE       = nib_r;
  assign NIBBLE_VALID = nib_vld_r;
  assign NIBBLE_IDX   = nib_cnt_r;
  assign XFER_END     = xfer_end_r;
  assign REPLY_REQ    = rep_req_r;
  assign REPLY_ACTIVE = rep_act_r;

endmodule

// ### rtl/gcd_pkg.sv
// constants, types and pattern decoding shared by the gap command detector
package gcd_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int QR_GAP_NS       = 175000;
  localparam int QR_FRAME_NS     = 1575000;
  localparam int NORM_SYMBOL_NS  = 2800000;
  localparam int FAST_SYMBOL_NS  = 160000;
  localparam int REPLY_SLOT_NS   = 2500000;
  localparam int QR_POSITIONS    = 9;
  localparam int PPM_POSITIONS   = 16;
  localparam int QR_SLOT_CYC     = QR_GAP_NS / CLK_PERIOD_NS;
  localparam int QR_FRAME_CYC    = QR_FRAME_NS / CLK_PERIOD_NS;
  localparam int NORM_SLOT_CYC   = NORM_SYMBOL_NS / PPM_POSITIONS / CLK_PERIOD_NS;
  localparam int FAST_SLOT_CYC   = FAST_SYMBOL_NS / PPM_POSITIONS / CLK_PERIOD_NS;
  localparam int REPLY_SLOT_CYC  = REPLY_SLOT_NS / CLK_PERIOD_NS;
  localparam int CAL_POS_B       = 6;
  localparam int CAL_POS_C       = 14;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SLOT   = 4'h8;
  localparam logic [3:0] ADDR_NIBBLE = 4'hC;
  localparam logic [1:0] CTRL_RESET  = 2'h1;
  localparam int CTRL_EN_BIT         = 0;
  localparam int CTRL_FAST_BIT       = 1;

  // --------------------------------------------------------------------
  // gap patterns, bit n-1 set for a gap in position n
  // --------------------------------------------------------------------
  localparam logic [8:0] PAT_S1_T1_N  = 9'h02F;
  localparam logic [8:0] PAT_S1_T1_F  = 9'h0B5;
  localparam logic [8:0] PAT_S1_T2_N  = 9'h01F;
  localparam logic [8:0] PAT_S1_T2_F  = 9'h075;
  localparam logic [8:0] PAT_S1_T4_N  = 9'h037;
  localparam logic [8:0] PAT_S1_T4_F  = 9'h0D5;
  localparam logic [8:0] PAT_S16_T1_N = 9'h0AB;
  localparam logic [8:0] PAT_S16_T1_F = 9'h0AD;
  localparam logic [8:0] PAT_S16_T2_N = 9'h06B;
  localparam logic [8:0] PAT_S16_T2_F = 9'h06D;
  localparam logic [8:0] PAT_S16_T4_N = 9'h03B;
  localparam logic [8:0] PAT_S16_T4_F = 9'h03D;
  localparam logic [8:0] PAT_S64_T1_N = 9'h05B;
  localparam logic [8:0] PAT_S64_T1_F = 9'h05D;
  localparam logic [8:0] SKIP_NORMAL_PATTERN = 9'h057;
  localparam logic [8:0] SKIP_FAST_PATTERN   = 9'h155;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FIRST = 3'h1,
    ST_CAL   = 3'h3,
    ST_SYM   = 3'h2,
    ST_QREAD = 3'h5
  } gcd_state_type;

  // slots code 0/1/2 = 1/16/64, tx code 0/1/2 = 1/2/4
  typedef struct packed {
    logic       hit;
    logic       skip;
    logic       fast;
    logic [1:0] slots;
    logic [1:0] tx;
  } gcd_qr_type;

  function automatic gcd_qr_type qr_decode(input logic [8:0] m);
    gcd_qr_type q;
    case (m)
      PAT_S1_T1_N:         q = gcd_qr_type'(7'h40);
      PAT_S1_T1_F:         q = gcd_qr_type'(7'h50);
      PAT_S1_T2_N:         q = gcd_qr_type'(7'h41);
      PAT_S1_T2_F:         q = gcd_qr_type'(7'h51);
      PAT_S1_T4_N:         q = gcd_qr_type'(7'h42);
      PAT_S1_T4_F:         q = gcd_qr_type'(7'h52);
      PAT_S16_T1_N:        q = gcd_qr_type'(7'h44);
      PAT_S16_T1_F:        q = gcd_qr_type'(7'h54);
      PAT_S16_T2_N:        q = gcd_qr_type'(7'h45);
      PAT_S16_T2_F:        q = gcd_qr_type'(7'h55);
      PAT_S16_T4_N:        q = gcd_qr_type'(7'h46);
      PAT_S16_T4_F:        q = gcd_qr_type'(7'h56);
      PAT_S64_T1_N:        q = gcd_qr_type'(7'h48);
      PAT_S64_T1_F:        q = gcd_qr_type'(7'h58);
      SKIP_NORMAL_PATTERN: q = gcd_qr_type'(7'h60);
      SKIP_FAST_PATTERN:   q = gcd_qr_type'(7'h70);
      default:             q = gcd_qr_type'(7'h00);
    endcase
    return q;
  endfunction

endpackage

// ### testbench/gcd_detector_assertions.sv
// port checks for the gap command detector
module gcd_detector_chk (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  // register port
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // decode results
  input wire logic        QR_REQ,
  input wire logic        QR_SKIP,
  input wire logic        SPEED_FAST,
  input wire logic [6:0]  MAX_SLOTS,
  input wire logic [2:0]  MAX_TX,
  // symbol stream
  input wire logic        CAL_DONE,
  input wire logic [3:0]  NIBBLE,
  input wire logic        NIBBLE_VALID,
  input wire logic [5:0]  NIBBLE_IDX,
  // replies
  input wire logic        MATCH_OK,
  input wire logic        REPLY_REQ,
  input wire logic        REPLY_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  wire qr_any = QR_REQ || QR_SKIP;
  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  chk_req_params: assert property (QR_REQ |=> (MAX_SLOTS inside {7'h01, 7'h10, 7'h40})
    && (MAX_TX inside {3'h1, 3'h2, 3'h4})) else $error("request parameters out of range");
  chk_skip_keeps: assert property (QR_SKIP |-> $stable(MAX_SLOTS) && $stable(MAX_TX))
    else $error("skip changed slot or transmit count");
  chk_one_decode: assert property (qr_any |=> !qr_any [*8])
    else $error("second decode inside one frame");
  // speed moves only on a decode or a control write
  chk_speed_cause: assert property ($changed(SPEED_FAST) |-> qr_any || $past(qr_any)
    || $past(REG_WR) || $past(REG_WR, 2)) else $error("speed changed without cause");
  chk_param_cause: assert property ($changed(MAX_SLOTS) || $changed(MAX_TX)
    |-> QR_REQ || $past(QR_REQ)) else $error("parameters changed without request");
  chk_idx_hold: assert property ($changed(NIBBLE_IDX) |-> NIBBLE_VALID
    || NIBBLE_IDX == 6'h00) else $error("nibble count moved without nibble");
  chk_nib_hold: assert property (!NIBBLE_VALID |-> $stable(NIBBLE))
    else $error("nibble changed without valid");
  chk_cal_quiet: assert property (CAL_DONE |=> !(CAL_DONE || NIBBLE_VALID) [*8])
    else $error("symbol too close to calibration");
  chk_reply_single: assert property (REPLY_REQ |-> MAX_SLOTS == 7'h01)
    else $error("reply outside single tag mode");
  chk_match_stop: assert property (MATCH_OK && !QR_REQ |-> ##[1:3] !REPLY_ACTIVE
    ##1 !REPLY_REQ [*8]) else $error("replies went on after match");
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind gcd_detector gcd_detector_chk u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .QR_REQ(QR_REQ), .QR_SKIP(QR_SKIP),
  .SPEED_FAST(SPEED_FAST), .MAX_SLOTS(MAX_SLOTS), .MAX_TX(MAX_TX), .CAL_DONE(CAL_DONE),
  .NIBBLE(NIBBLE), .NIBBLE_VALID(NIBBLE_VALID), .NIBBLE_IDX(NIBBLE_IDX),
  .MATCH_OK(MATCH_OK), .REPLY_REQ(REPLY_REQ), .REPLY_ACTIVE(REPLY_ACTIVE));

// ### testbench/gcd_interrogator.sv
// interrogator model: carrier gaps for quick read frames and 1-of-16 symbols
module gcd_interrogator
  import gcd_pkg::*;
#(
  parameter int QSLOT = QR_SLOT_CYC
) (
  // clock
  input wire logic REF_CLK,
  // high during a carrier gap
  output logic     GAP
);
  timeunit 1ns;
  timeprecision 1ps;
  initial GAP = 1'b0;
  // one position of len cycles, gap of w cycles starting skew cycles in
  task automatic pos(input logic g, input int w, input int len, input int skew);
    repeat (skew) @(posedge REF_CLK);
    GAP <= g;
    repeat (w) @(posedge REF_CLK);
    GAP <= 1'b0;
    repeat (len - w - skew) @(posedge REF_CLK);
  endtask
  // gaps end a quarter slot early: adjacent gaps must show a fresh start
  task automatic send_qr(input logic [8:0] m);
    for (int i = 0; i < QR_POSITIONS; i++) pos(m[i], QSLOT * 3 / 4, QSLOT, 0);
  endtask
  // calibration then one symbol of sixteen positions per nibble
  task automatic send_ppm(input int s, input logic [3:0] v[$], input int skew);
    for (int p = 0; p < PPM_POSITIONS; p++)
      pos(p == 0 || p == CAL_POS_B || p == CAL_POS_C, s * 4 / 7, s, 0);
    foreach (v[k])
      for (int p = 0; p < PPM_POSITIONS; p++) pos(p == v[k], s * 4 / 7, s, skew);
  endtask
endmodule

// ### testbench/gcd_detector_tb.sv
// self-checking bench for the gap command detector
module gcd_detector_tb
  import gcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QS = 100;
  localparam int NS = 100;
  localparam int FS = 8;
  localparam int RS = 200;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        match_ok = 1'b0;
  logic        gap;
  logic [31:0] rdata;
  logic        qr_req, qr_skip, speed_fast, cal_done, nib_valid, xfer_end, reply_req, reply_act;
  logic [6:0]  max_slots;
  logic [2:0]  max_tx;
  logic [3:0]  nibble;
  logic [5:0]  nib_idx;
  logic [3:0]  nibs[$];
  logic [3:0]  nq[$];
  int          errors = 0;
  int          tests_run = 0;
  int          n_req = 0, n_skip = 0, n_cal = 0, n_end = 0, n_rep = 0;
  int          c, e, r;

  always #4 ref_clk = ~ref_clk;

  gcd_detector #(.QR_SLOT(QS), .NORM_SLOT(NS), .FAST_SLOT(FS), .REPLY_SLT(RS))
    uut (.REF_CLK(ref_clk),
    .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(rdata), .GAP(gap), .QR_REQ(qr_req), .QR_SKIP(qr_skip),
    .SPEED_FAST(speed_fast), .MAX_SLOTS(max_slots), .MAX_TX(max_tx), .CAL_DONE(cal_done),
    .NIBBLE(nibble), .NIBBLE_VALID(nib_valid), .NIBBLE_IDX(nib_idx), .XFER_END(xfer_end),
    .MATCH_OK(match_ok), .REPLY_REQ(reply_req), .REPLY_ACTIVE(reply_act));
  gcd_interrogator #(.QSLOT(QS)) part (.REF_CLK(ref_clk), .GAP(gap));

  // pulses counted mid-cycle, away from the edge that updates them
  always @(negedge ref_clk) begin
    if (qr_req === 1'b1) n_req++;
    if (qr_skip === 1'b1) n_skip++;
    if (cal_done === 1'b1) n_cal++;
    if (xfer_end === 1'b1) n_end++;
    if (reply_req === 1'b1) n_rep++;
    if (nib_valid === 1'b1) nibs.push_back(nibble);
  end
  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, x);
  endtask
  function automatic logic [8:0] m5(input int a, b, c, d, e);
    return (9'h1 << (a - 1)) | (9'h1 << (b - 1)) | (9'h1 << (c - 1))
      | (9'h1 << (d - 1)) | (9'h1 << (e - 1));
  endfunction
  // one frame, then pulse counts and the parameters left standing
  task automatic qf(input logic [8:0] m, input int req, skp, f, sl, tx);
    int r0;
    int s0;
    r0 = n_req;
    s0 = n_skip;
    @(posedge ref_clk);
    part.send_qr(m);
    repeat (QS) @(posedge ref_clk);
    chk(n_req - r0, req);
    chk(n_skip - s0, skp);
    chk(speed_fast, f);
    chk(max_slots, sl);
    chk(max_tx, tx);
  endtask
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk({qr_req, qr_skip, speed_fast, cal_done, nib_valid, xfer_end, reply_req, reply_act}, 0);
    chk({max_slots, max_tx}, {7'h01, 3'h1});
    rd(ADDR_CTRL, 32'h1);
    wr(ADDR_STATUS, 32'hFFFF);
    rd(ADDR_STATUS, 32'h1);
    rd(4'h2, 32'h0);
    qf(m5(1, 2, 3, 4, 6), 1, 0, 0, 1, 1);
    qf(m5(1, 3, 5, 6, 8), 1, 0, 1, 1, 1);
    qf(m5(1, 2, 3, 4, 5), 1, 0, 0, 1, 2);
    qf(m5(1, 3, 5, 6, 7), 1, 0, 1, 1, 2);
    qf(m5(1, 2, 3, 5, 6), 1, 0, 0, 1, 4);
    qf(m5(1, 3, 5, 7, 8), 1, 0, 1, 1, 4);
    qf(m5(1, 2, 4, 6, 8), 1, 0, 0, 16, 1);
    qf(m5(1, 3, 4, 6, 8), 1, 0, 1, 16, 1);
    qf(m5(1, 2, 4, 6, 7), 1, 0, 0, 16, 2);
    qf(m5(1, 3, 4, 6, 7), 1, 0, 1, 16, 2);
    qf(m5(1, 2, 4, 5, 6), 1, 0, 0, 16, 4);
    qf(m5(1, 3, 4, 5, 6), 1, 0, 1, 16, 4);
    qf(m5(1, 2, 4, 5, 7), 1, 0, 0, 64, 1);
    qf(m5(1, 3, 4, 5, 7), 1, 0, 1, 64, 1);
    qf(m5(1, 2, 3, 5, 7), 0, 1, 0, 64, 1);
    qf(m5(1, 3, 5, 7, 9), 0, 1, 1, 64, 1);
    qf(m5(1, 2, 3, 4, 7), 0, 0, 1, 64, 1);
    wr(ADDR_CTRL, 32'h2);
    qf(m5(1, 2, 4, 5, 6), 0, 0, 1, 64, 1);
    wr(ADDR_CTRL, 32'h1);
    r = n_rep;
    qf(m5(1, 2, 3, 4, 5), 1, 0, 0, 1, 2);
    repeat (3 * RS) @(posedge ref_clk);
    chk(n_rep - r, 2);
    r = n_rep;
    qf(m5(1, 2, 3, 5, 6), 1, 0, 0, 1, 4);
    match_ok <= 1'b1;
    @(posedge ref_clk);
    match_ok <= 1'b0;
    repeat (4 * RS) @(posedge ref_clk);
    chk(n_rep - r, 1);
    chk(reply_act, 0);
    r = n_rep;
    qf(m5(1, 2, 4, 6, 8), 1, 0, 0, 16, 1);
    repeat (2 * RS) @(posedge ref_clk);
    chk(n_rep - r, 0);
    // a normal calibration must be refused once the speed is fast
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS, 32'h7);
    c = n_cal;
    nq = '{4'h3};
    @(posedge ref_clk);
    part.send_ppm(NS, nq, 0);
    chk(n_cal - c, 0);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk({speed_fast, max_slots}, {1'b0, 7'h01});
    c = n_cal;
    e = n_end;
    nibs.delete();
    nq = '{4'h0, 4'hF, 4'h6, 4'h9};
    @(posedge ref_clk);
    part.send_ppm(NS, nq, NS / 4);
    chk(n_cal - c, 1);
    chk(nibs.size(), 4);
    foreach (nq[k]) chk(nibs[k], nq[k]);
    chk(nib_idx, 4);
    rd(ADDR_SLOT, NS);
    rd(ADDR_NIBBLE, 32'h9);
    repeat (20 * NS) @(posedge ref_clk);
    chk(n_end - e, 1);
    wr(ADDR_CTRL, 32'h3);
    c = n_cal;
    nibs.delete();
    nq = '{4'hA};
    @(posedge ref_clk);
    part.send_ppm(FS, nq, FS / 4);
    chk(n_cal - c, 1);
    chk(nibs[0], 4'hA);
    close_out();
  end
endmodule
